// ==== include/iwdt_cfg.svh ====
// Register map, field positions and reset values of the interval and watchdog timer.
// Assumes inclusion by bare name from files compiled with the include folder on the path.
`ifndef IWDT_CFG_SVH
`define IWDT_CFG_SVH

// Register indices; byte address is four times the index
`define REG_IDX_INTERVAL_CTRL   8'h8b
`define REG_IDX_INTERVAL_COUNT  8'h8c
`define REG_IDX_WATCHDOG_CTRL   8'h8d
`define REG_IDX_WATCHDOG_COUNT  8'h8e
`define REG_IDX_IRQ_STATUS      8'h90
`define REG_IDX_IRQ_MASK        8'h91

// Interval timer control fields
`define ITC_IRQ_FLAG_BIT        7
`define ITC_CLEAR_BIT           3
`define ITC_SEL_LSB             0
`define ITC_RESET_VALUE         8'h01
`define ITC_SEL_RESET           3'h1

// Watchdog control fields
`define WDC_ENABLE_BIT          7
`define WDC_RESET_EN_BIT        6
`define WDC_CLEAR_BIT           5
`define WDC_IRQ_FLAG_BIT        0
`define WDC_RESET_VALUE         8'h00

// Compare register default
`define WDT_COMPARE_RESET       8'hff

// Event status and mask layout
`define EVT_INTERVAL_BIT        0
`define EVT_WATCHDOG_BIT        1
`define EVT_RESET_VALUE         2'h0

// Bus handshake outputs after reset: awready, wready, bvalid, arready, rvalid
`define HS_RESET_VALUE          5'h1a

// Width of the CPU reset pulse in clocks
`define CPU_RESET_CYCLES        4'h8

// AXI responses
`define AXI_RESP_OKAY           2'h0
`define AXI_RESP_SLVERR         2'h2

`endif

// ==== include/iwdt_pkg.sv ====
// Types shared by the interval and watchdog timer files.
// Assumes nothing beyond a SystemVerilog compiler.
package iwdt_pkg;
  typedef enum logic [1:0] {
    WR_IDLE,
    WR_RESP
  } wr_state_t;

  typedef enum logic [0:0] {
    RD_IDLE,
    RD_RESP
  } rd_state_t;
endpackage

// ==== hw/interval_counter.sv ====
// Free-running 8-bit interval counter with selectable overflow tick.
// Assumes one clock and a synchronous active-low reset.
`include "iwdt_cfg.svh"
module interval_counter
  import iwdt_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clear,
  input  wire logic [2:0]       sel,
  output logic      [WIDTH-1:0] count,
  output logic                  tick
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic             tick_r;
  logic             tick_nxt;

  always_comb begin
    count_nxt = clear ? '0 : count_r + 1'b1;
    // Overflow of the selected bit is its fall from one to zero
    tick_nxt  = !clear && count_r[sel] && !count_nxt[sel];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
      tick_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      tick_r  <= tick_nxt;
    end
  end

  assign count = count_r;
  assign tick  = tick_r;
endmodule

// ==== hw/watchdog_counter.sv ====
// 8-bit watchdog counter advanced by the interval tick, restarting on match.
// Assumes tick is a one-cycle pulse on the same clock.
`include "iwdt_cfg.svh"
module watchdog_counter
  import iwdt_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             enable,
  input  wire logic             clear,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] compare,
  output logic      [WIDTH-1:0] count,
  output logic                  match
);
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic             match_r;
  logic             match_nxt;

  always_comb begin
    count_nxt = count_r;
    match_nxt = 1'b0;
    if (clear || !enable) begin
      count_nxt = '0;
    end else if (tick) begin
      // Count reaches compare after compare ticks from zero; match comes on the next tick
      if (count_r == compare) begin
        match_nxt = 1'b1;
        count_nxt = '0;
      end else begin
        count_nxt = count_r + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
      match_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      match_r <= match_nxt;
    end
  end

  assign count = count_r;
  assign match = match_r;
endmodule

// ==== hw/interval_and_watchdog_timer.sv ====
// Interval timer and watchdog timer with an AXI4-Lite register slave.
// Assumes a single 25 MHz clock, synchronous active-low reset, acknowledge on the same clock.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`include "iwdt_cfg.svh"
module interval_and_watchdog_timer
  import iwdt_pkg::*;
#(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  int_ack_interval,
  input  wire logic                  int_ack_watchdog,
  output logic                       irq,
  output logic                       cpu_reset
);
  // Word index from a byte address
  function automatic logic [7:0] word_index(input logic [ADDR_WIDTH-1:0] a);
    word_index = a[9:2];
  endfunction

  function automatic logic index_known(input logic [7:0] i);
    index_known = (i == `REG_IDX_INTERVAL_CTRL) || (i == `REG_IDX_INTERVAL_COUNT)
               || (i == `REG_IDX_WATCHDOG_CTRL) || (i == `REG_IDX_WATCHDOG_COUNT)
               || (i == `REG_IDX_IRQ_STATUS)    || (i == `REG_IDX_IRQ_MASK);
  endfunction

  // Register state
  logic       itc_flag_r,   itc_flag_nxt;
  logic       itc_clear_r,  itc_clear_nxt;
  logic [2:0] itc_sel_r,    itc_sel_nxt;
  logic       wdc_en_r,     wdc_en_nxt;
  logic       wdc_rsten_r,  wdc_rsten_nxt;
  logic       wdc_clear_r,  wdc_clear_nxt;
  logic       wdc_flag_r,   wdc_flag_nxt;
  logic [7:0] compare_r,    compare_nxt;
  logic [1:0] evt_status_r, evt_status_nxt;
  logic [1:0] evt_mask_r,   evt_mask_nxt;
  logic       irq_r,        irq_nxt;
  logic       cpu_reset_r,  cpu_reset_nxt;
  logic [3:0] rst_cnt_r,    rst_cnt_nxt;

  // Bus state
  wr_state_t         wr_state_r,  wr_state_nxt;
  rd_state_t         rd_state_r,  rd_state_nxt;
  logic              aw_held_r,   aw_held_nxt;
  logic              w_held_r,    w_held_nxt;
  logic [7:0]        aw_idx_r,    aw_idx_nxt;
  logic [31:0]       w_data_r,    w_data_nxt;
  logic              w_lane0_r,   w_lane0_nxt;
  logic [1:0]        bresp_r,     bresp_nxt;
  logic [31:0]       rdata_r,     rdata_nxt;
  logic [1:0]        rresp_r,     rresp_nxt;
  // Handshake outputs, in order awready, wready, bvalid, arready, rvalid
  logic [4:0]        hs_r,        hs_nxt;

  logic [7:0] interval_count;
  logic       interval_tick;
  logic [7:0] watchdog_count;
  logic       watchdog_match;

  interval_counter #(
    .WIDTH (8)
  ) u_interval (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (itc_clear_r),
    .sel     (itc_sel_r),
    .count   (interval_count),
    .tick    (interval_tick)
  );

  watchdog_counter #(
    .WIDTH (8)
  ) u_watchdog (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (wdc_en_r),
    .clear   (wdc_clear_r),
    .tick    (interval_tick),
    .compare (compare_r),
    .count   (watchdog_count),
    .match   (watchdog_match)
  );

  logic wr_go;
  logic wr_ok;

  // Write and read channel sequencing
  always_comb begin
    wr_state_nxt = wr_state_r;
    aw_held_nxt  = aw_held_r;
    w_held_nxt   = w_held_r;
    aw_idx_nxt   = aw_idx_r;
    w_data_nxt   = w_data_r;
    w_lane0_nxt  = w_lane0_r;
    bresp_nxt    = bresp_r;
    wr_go        = 1'b0;
    case (wr_state_r)
      WR_IDLE: begin
        if (s_axi_awvalid && !aw_held_r) begin
          aw_held_nxt = 1'b1;
          aw_idx_nxt  = word_index(s_axi_awaddr);
        end
        if (s_axi_wvalid && !w_held_r) begin
          w_held_nxt  = 1'b1;
          w_data_nxt  = s_axi_wdata;
          w_lane0_nxt = s_axi_wstrb[0];
        end
        if (aw_held_r && w_held_r) begin
          wr_go        = 1'b1;
          bresp_nxt    = index_known(aw_idx_r) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
          aw_held_nxt  = 1'b0;
          w_held_nxt   = 1'b0;
          wr_state_nxt = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_nxt = WR_IDLE;
        end
      end
      default: wr_state_nxt = WR_IDLE;
    endcase
  end

  assign wr_ok = wr_go && w_lane0_r;

  always_comb begin
    rd_state_nxt = rd_state_r;
    rdata_nxt    = rdata_r;
    rresp_nxt    = rresp_r;
    case (rd_state_r)
      RD_IDLE: begin
        if (s_axi_arvalid) begin
          rd_state_nxt = RD_RESP;
          rresp_nxt    = `AXI_RESP_OKAY;
          rdata_nxt    = 32'h0000_0000;
          case (word_index(s_axi_araddr))
            `REG_IDX_INTERVAL_CTRL:
              rdata_nxt[7:0] = {itc_flag_r, 3'h0, itc_clear_r, itc_sel_r};
            `REG_IDX_INTERVAL_COUNT: rdata_nxt[7:0] = interval_count;
            `REG_IDX_WATCHDOG_CTRL:
              rdata_nxt[7:0] = {wdc_en_r, wdc_rsten_r, wdc_clear_r, 4'h0, wdc_flag_r};
            `REG_IDX_WATCHDOG_COUNT: rdata_nxt[7:0] = watchdog_count;
            `REG_IDX_IRQ_STATUS:     rdata_nxt[1:0] = evt_status_r;
            `REG_IDX_IRQ_MASK:       rdata_nxt[1:0] = evt_mask_r;
            default:                 rresp_nxt      = `AXI_RESP_SLVERR;
          endcase
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          rd_state_nxt = RD_IDLE;
        end
      end
      default: rd_state_nxt = RD_IDLE;
    endcase
  end

  // Register effects of writes and hardware events
  always_comb begin
    logic wd_event;
    logic wr_itc;
    logic wr_wdc;
    wd_event       = watchdog_match && !wdc_rsten_r;
    wr_itc         = wr_ok && (aw_idx_r == `REG_IDX_INTERVAL_CTRL);
    wr_wdc         = wr_ok && (aw_idx_r == `REG_IDX_WATCHDOG_CTRL);
    itc_sel_nxt    = itc_sel_r;
    itc_clear_nxt  = 1'b0;
    wdc_en_nxt     = wdc_en_r;
    wdc_rsten_nxt  = wdc_rsten_r;
    wdc_clear_nxt  = 1'b0;
    compare_nxt    = compare_r;
    evt_mask_nxt   = evt_mask_r;
    evt_status_nxt = evt_status_r;
    itc_flag_nxt   = itc_flag_r;
    wdc_flag_nxt   = wdc_flag_r;
    if (wr_itc) begin
      itc_sel_nxt   = w_data_r[`ITC_SEL_LSB +: 3];
      itc_clear_nxt = w_data_r[`ITC_CLEAR_BIT];
      if (!w_data_r[`ITC_IRQ_FLAG_BIT]) begin
        itc_flag_nxt = 1'b0;
      end
    end
    if (wr_wdc) begin
      wdc_en_nxt    = w_data_r[`WDC_ENABLE_BIT];
      wdc_rsten_nxt = w_data_r[`WDC_RESET_EN_BIT];
      wdc_clear_nxt = w_data_r[`WDC_CLEAR_BIT];
      if (!w_data_r[`WDC_IRQ_FLAG_BIT]) begin
        wdc_flag_nxt = 1'b0;
      end
    end
    if (wr_ok && (aw_idx_r == `REG_IDX_WATCHDOG_COUNT)) begin
      compare_nxt = w_data_r[7:0];
    end
    if (wr_ok && (aw_idx_r == `REG_IDX_IRQ_MASK)) begin
      evt_mask_nxt = w_data_r[1:0];
    end
    if (wr_ok && (aw_idx_r == `REG_IDX_IRQ_STATUS)) begin
      evt_status_nxt = evt_status_r & ~w_data_r[1:0];
    end
    if (int_ack_interval) begin
      itc_flag_nxt = 1'b0;
    end
    if (int_ack_watchdog) begin
      wdc_flag_nxt = 1'b0;
    end
    // Sets come last so an event in the clearing cycle is kept
    if (interval_tick) begin
      itc_flag_nxt = 1'b1;
      evt_status_nxt[`EVT_INTERVAL_BIT] = 1'b1;
    end
    if (wd_event) begin
      wdc_flag_nxt = 1'b1;
      evt_status_nxt[`EVT_WATCHDOG_BIT] = 1'b1;
    end
    irq_nxt = |(evt_status_nxt & evt_mask_nxt);
    // A match in watchdog mode yields a fixed-width CPU reset pulse
    rst_cnt_nxt = rst_cnt_r;
    if (watchdog_match && wdc_rsten_r) begin
      rst_cnt_nxt = `CPU_RESET_CYCLES;
    end else if (rst_cnt_r != 4'h0) begin
      rst_cnt_nxt = rst_cnt_r - 4'h1;
    end
    cpu_reset_nxt = (rst_cnt_nxt != 4'h0);
    hs_nxt = {(wr_state_nxt == WR_IDLE) && !aw_held_nxt,
              (wr_state_nxt == WR_IDLE) && !w_held_nxt,
              wr_state_nxt == WR_RESP, rd_state_nxt == RD_IDLE, rd_state_nxt == RD_RESP};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      itc_flag_r   <= 1'b0;
      itc_clear_r  <= 1'b0;
      itc_sel_r    <= `ITC_SEL_RESET;
      wdc_en_r     <= 1'b0;
      wdc_rsten_r  <= 1'b0;
      wdc_clear_r  <= 1'b0;
      wdc_flag_r   <= 1'b0;
      compare_r    <= `WDT_COMPARE_RESET;
      evt_status_r <= `EVT_RESET_VALUE;
      evt_mask_r   <= `EVT_RESET_VALUE;
      irq_r        <= 1'b0;
      cpu_reset_r  <= 1'b0;
      rst_cnt_r    <= 4'h0;
      wr_state_r   <= WR_IDLE;
      rd_state_r   <= RD_IDLE;
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      aw_idx_r     <= 8'h00;
      w_data_r     <= 32'h0000_0000;
      w_lane0_r    <= 1'b0;
      bresp_r      <= `AXI_RESP_OKAY;
      rdata_r      <= 32'h0000_0000;
      rresp_r      <= `AXI_RESP_OKAY;
      hs_r         <= `HS_RESET_VALUE;
    end else begin
      itc_flag_r   <= itc_flag_nxt;
      itc_clear_r  <= itc_clear_nxt;
      itc_sel_r    <= itc_sel_nxt;
      wdc_en_r     <= wdc_en_nxt;
      wdc_rsten_r  <= wdc_rsten_nxt;
      wdc_clear_r  <= wdc_clear_nxt;
      wdc_flag_r   <= wdc_flag_nxt;
      compare_r    <= compare_nxt;
      evt_status_r <= evt_status_nxt;
      evt_mask_r   <= evt_mask_nxt;
      irq_r        <= irq_nxt;
      cpu_reset_r  <= cpu_reset_nxt;
      rst_cnt_r    <= rst_cnt_nxt;
      wr_state_r   <= wr_state_nxt;
      rd_state_r   <= rd_state_nxt;
      aw_held_r    <= aw_held_nxt;
      w_held_r     <= w_held_nxt;
      aw_idx_r     <= aw_idx_nxt;
      w_data_r     <= w_data_nxt;
      w_lane0_r    <= w_lane0_nxt;
      bresp_r      <= bresp_nxt;
      rdata_r      <= rdata_nxt;
      rresp_r      <= rresp_nxt;
      hs_r         <= hs_nxt;
    end
  end

  // Handshakes come from their own flops, decoded one cycle early from the next state
  assign s_axi_awready = hs_r[4];
  assign s_axi_wready  = hs_r[3];
  assign s_axi_bvalid  = hs_r[2];
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = hs_r[1];
  assign s_axi_rvalid  = hs_r[0];
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign irq           = irq_r;
  assign cpu_reset     = cpu_reset_r;
endmodule

// ==== verification/iwdt_asserts.sv ====
// Bus handshake and reset-pulse checks for the interval and watchdog timer.
// Assumes it is bound to the top module and sees only its ports.
module iwdt_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cpu_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
  // Response drops exactly at the edge that takes it
  property p_b_hold;
    s_axi_bvalid |=> s_axi_bvalid != $past(s_axi_bready);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response mishandled");
  property p_r_hold;
    s_axi_rvalid |=> s_axi_rvalid != $past(s_axi_rready);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read response mishandled");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
  property p_w_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_busy: assert property (p_w_busy) else $error("write taken while busy");
  property p_rdata_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");
  property p_reset_len;
    $rose(cpu_reset) |-> cpu_reset [*8] ##1 !cpu_reset;
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("cpu reset width wrong");
endmodule

bind interval_and_watchdog_timer iwdt_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .cpu_reset(cpu_reset)
);

// ==== verification/tb.sv ====
// Self-checking bench for the interval and watchdog timer over AXI4-Lite.
// Assumes the checker is bound separately; drives every design input itself.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_ITC = 12'h22c;
  localparam logic [11:0] A_ICNT = 12'h230;
  localparam logic [11:0] A_WDC = 12'h234;
  localparam logic [11:0] A_WDN = 12'h238;
  localparam logic [11:0] A_STS = 12'h240;
  localparam logic [11:0] A_MSK = 12'h244;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, cpu_reset;
  logic [1:0]  bresp, rresp;
  logic        ack_i = 1'b0, ack_w = 1'b0;
  int          fails = 0, total_checks = 0, cyc = 0;

  always #20 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  interval_and_watchdog_timer uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .int_ack_interval(ack_i), .int_ack_watchdog(ack_w), .irq(irq), .cpu_reset(cpu_reset)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic hang(input string m);
    fails++;
    $display("unexpected at %0t: timeout in %s", $time, m);
    wrap_up();
  endtask

  // Ready and valid come from flops, so the falling edge shows what the next rising edge samples
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 20 && !(ta && tw); n++) begin
      @(negedge aclk);
      if (awvalid && awready) ta = 1'b1;
      if (wvalid && wready) tw = 1'b1;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    if (!(ta && tw)) hang("write address");
    n = 0;
    do begin @(negedge aclk); n++; end while (bvalid !== 1'b1 && n < 20);
    if (bvalid !== 1'b1) hang("write response");
    chk(bresp, er, "write response code");
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] er = 2'h0);
    int n;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    n = 0;
    do begin @(negedge aclk); n++; end while (arready !== 1'b1 && n < 20);
    if (arready !== 1'b1) hang("read address");
    @(posedge aclk);
    arvalid <= 1'b0;
    n = 0;
    do begin @(negedge aclk); n++; end while (rvalid !== 1'b1 && n < 20);
    if (rvalid !== 1'b1) hang("read");
    d = rdata;
    chk(rresp, er, "read response code");
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    do begin @(negedge aclk); n++; end while (irq !== lvl && n < 2000);
    if (irq !== lvl) hang("irq");
  endtask

  // Cycles between two unmasked events; the status is cleared in between
  task automatic period(input logic [1:0] m, output int p);
    int t1;
    wr(A_MSK, {30'h0, m});
    wr(A_STS, 32'h0000_0003);
    // Clear just after an event, so the clear cannot meet a set in the same cycle
    wait_irq(1'b1);
    wr(A_STS, {30'h0, m});
    wait_irq(1'b0);
    wait_irq(1'b1);
    t1 = cyc;
    wr(A_STS, {30'h0, m});
    wait_irq(1'b0);
    wait_irq(1'b1);
    p = cyc - t1;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    rd(A_ITC, d); chk(d, 32'h0000_0001, "interval control reset");
    rd(A_WDC, d); chk(d, 32'h0000_0000, "watchdog control reset");
    rd(A_WDN, d); chk(d, 32'h0000_0000, "watchdog count reset");
    rd(A_MSK, d); chk(d, 32'h0000_0000, "mask reset");
    rd(12'h3fc, d, 2'h2); chk(d, 32'h0000_0000, "unmapped read");
    wr(12'h3fc, 32'h0000_00ff, 2'h2);
  endtask

  task automatic t_interval();
    logic [31:0] d, e;
    wr(A_ITC, 32'h0000_000f);
    rd(A_ITC, d); chk(d, 32'h0000_0007, "clear bit self-clears");
    rd(A_ICNT, d); chk(32'(d < 32'd40), 32'h1, "counter restarted");
    rd(A_ICNT, e); chk(32'(e != d), 32'h1, "counter runs");
    repeat (300) @(posedge aclk);
    rd(A_ITC, d); chk(d, 32'h0000_0087, "flag on overflow");
    wr(A_ITC, 32'h0000_0007);
    rd(A_ITC, d); chk(d, 32'h0000_0007, "flag cleared by zero");
    repeat (256) @(posedge aclk);
    ack_i <= 1'b1;
    @(posedge aclk);
    ack_i <= 1'b0;
    rd(A_ITC, d); chk(d, 32'h0000_0007, "flag cleared by acknowledge");
  endtask

  task automatic t_select();
    int p;
    for (int s = 3; s < 8; s++) begin
      wr(A_ITC, 32'(s));
      period(2'b01, p); chk(32'(p), 32'(2 ** (s + 1)), "overflow period");
    end
    wr(A_MSK, 32'h0000_0000);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0, "masked irq low");
  endtask

  task automatic t_watchdog();
    logic [31:0] d;
    int p;
    wr(A_ITC, 32'h0000_0003);
    wr(A_WDN, 32'h0000_0003);
    wr(A_WDC, 32'h0000_00a0);
    period(2'b10, p); chk(32'(p), 32'd64, "watchdog interval");
    rd(A_WDC, d); chk(d, 32'h0000_0081, "watchdog flag set");
    wr(A_WDC, 32'h0000_0080);
    rd(A_WDC, d); chk(d, 32'h0000_0080, "flag cleared by zero");
    rd(A_WDN, d); chk(32'(d <= 32'd3), 32'h1, "read returns counter");
    wr(A_STS, 32'h0000_0003);
    wait_irq(1'b1);
    @(posedge aclk);
    ack_w <= 1'b1;
    @(posedge aclk);
    ack_w <= 1'b0;
    rd(A_WDC, d); chk(d, 32'h0000_0080, "flag cleared by acknowledge");
    wr(A_WDC, 32'h0000_0000);
    repeat (40) @(posedge aclk);
    rd(A_WDN, d); chk(d, 32'h0000_0000, "disabled watchdog idle");
  endtask

  task automatic t_reset_mode();
    logic [31:0] d;
    int n;
    wr(A_ITC, 32'h0000_0002);
    wr(A_WDN, 32'h0000_0001);
    wr(A_STS, 32'h0000_0003);
    wr(A_WDC, 32'h0000_00e0);
    n = 0;
    do begin @(negedge aclk); n++; end while (cpu_reset !== 1'b1 && n < 100);
    if (cpu_reset !== 1'b1) hang("cpu reset");
    n = 0;
    while (cpu_reset === 1'b1 && n < 20) begin @(negedge aclk); n++; end
    chk(32'(n), 32'd8, "cpu reset width");
    rd(A_WDC, d); chk(d, 32'h0000_00c0, "no flag in reset mode");
    rd(A_STS, d); chk(d & 32'h2, 32'h0, "no watchdog event");
    wr(A_WDC, 32'h0000_0000);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_interval();
    t_select();
    t_watchdog();
    t_reset_mode();
    wrap_up();
  end

  initial begin
    repeat (100000) @(posedge aclk);
    hang("run");
  end
endmodule
